// *** logic/sstk_pkg.sv ***
// Package for the software stack pointer block: widths, reset values, ops.
// Assumes a 16-bit data space and a 23-bit program counter.
package sstk_pkg;
  localparam int SSTK_DW = 16;
  localparam int SSTK_PCW = 23;
  localparam int SSTK_PC_LO_W = 16;
  localparam int SSTK_PC_HI_W = 7;
  localparam int SSTK_SRL_W = 8;
  localparam logic [15:0] SSTK_RESET_ADDR = 16'h1000;
  localparam logic [15:0] SSTK_WORD_STEP = 16'h0002;
  localparam logic [15:0] SSTK_ALIGN_MASK = 16'hFFFE;
  localparam logic [15:0] SSTK_FP_RESET = 16'h0000;
  localparam logic [7:0] SSTK_ZERO_BYTE = 8'h00;
  typedef enum logic [2:0] {
    SSTK_OP_NONE,
    SSTK_OP_PUSH,
    SSTK_OP_POP,
    SSTK_OP_CALL,
    SSTK_OP_EXC,
    SSTK_OP_RET,
    SSTK_OP_RETFIE
  } sstk_op_t;
endpackage

// *** logic/sstk_addr_step.sv ***
// Pointer step unit: aligned increment or decrement of a 16-bit pointer.
// Assumes callers pass word-aligned pointers; carries wrap within 16 bits.
`timescale 1ns/1ps
module sstk_addr_step (
  input wire logic [sstk_pkg::SSTK_DW-1:0] ptr_i,
  output logic [sstk_pkg::SSTK_DW-1:0] inc_o,
  output logic [sstk_pkg::SSTK_DW-1:0] dec_o
);
  import sstk_pkg::*;
  // Sixteen-bit arithmetic keeps the pointer out of paged space [R8]
  assign inc_o = (ptr_i + SSTK_WORD_STEP) & SSTK_ALIGN_MASK;
  assign dec_o = (ptr_i - SSTK_WORD_STEP) & SSTK_ALIGN_MASK;
endmodule

// *** logic/sstk_frame_word.sv ***
// Builds the second saved word of a program counter push.
// Assumes the sequencer tells calls apart from exception entry.
`timescale 1ns/1ps
module sstk_frame_word (
  input wire logic [sstk_pkg::SSTK_PC_HI_W-1:0] pc_hi_i,
  input wire logic [sstk_pkg::SSTK_SRL_W-1:0] status_low_byte_i,
  input wire logic is_exc_i,
  output logic [sstk_pkg::SSTK_DW-1:0] word_o
);
  import sstk_pkg::*;
  logic [SSTK_SRL_W-1:0] low_sel;
  assign low_sel = is_exc_i ? status_low_byte_i : SSTK_ZERO_BYTE; // [R7]
  // Upper byte carries the PC high bits, zero filled above them [R6]
  assign word_o = {1'b0, pc_hi_i, low_sel};
endmodule

// *** logic/sstk_core.sv ***
// Software stack pointer core: pointer register, push/pop sequencing.
// Assumes the sequencer holds op_i until done_o and memory answers in 1 cycle.
//
// Contract
// R1: Bit 0 of the stack pointer is always zero whatever is written.
// R2: Every reset loads the stack pointer with 0x1000.
// R3: The pointer addresses the next free word and the stack grows upward.
// R4: Pop decrements then reads; push writes then increments.
// R5: A PC save writes PC low 16 bits first, then PC bits 22 to 16.
// R6: On a call the second saved word is zero above the PC high bits.
// R7: On exception entry the second word holds the status low byte too.
// R8: Stack pointer addresses are 16-bit only and never paged.
// R9: With frame pointer mode set, the frame pointer is 16-bit unpaged.
// R10: Any instruction can read, write and compute on the stack pointer.
// R11: Calls, returns and exceptions move the pointer without software.
`timescale 1ns/1ps
module sstk_core (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire sstk_pkg::sstk_op_t op_i,
  input wire logic [sstk_pkg::SSTK_DW-1:0] push_data_i,
  input wire logic [sstk_pkg::SSTK_PCW-1:0] pc_i,
  input wire logic [sstk_pkg::SSTK_SRL_W-1:0] status_low_byte_i,
  input wire logic wreg_we_i,
  input wire logic [sstk_pkg::SSTK_DW-1:0] wreg_wdata_i,
  input wire logic fp_we_i,
  input wire logic [sstk_pkg::SSTK_DW-1:0] fp_wdata_i,
  input wire logic frame_pointer_active_i,
  input wire logic [sstk_pkg::SSTK_DW-1:0] mem_rdata_i,
  output logic [sstk_pkg::SSTK_DW-1:0] stack_pointer_reg_o,
  output logic [sstk_pkg::SSTK_DW-1:0] frame_pointer_reg_o,
  output logic fp_unpaged_o,
  output logic mem_we_o,
  output logic mem_re_o,
  output logic [sstk_pkg::SSTK_DW-1:0] mem_addr_o,
  output logic [sstk_pkg::SSTK_DW-1:0] mem_wdata_o,
  output logic extended_space_paging_o,
  output logic [sstk_pkg::SSTK_DW-1:0] pop_data_o,
  output logic [sstk_pkg::SSTK_PCW-1:0] ret_pc_o,
  output logic [sstk_pkg::SSTK_SRL_W-1:0] ret_srl_o,
  output logic ret_srl_valid_o,
  output logic done_o
);
  import sstk_pkg::*;

  typedef enum logic [2:0] {
    SSTK_IDLE,
    SSTK_WR_LO,
    SSTK_WR_HI,
    SSTK_RD_HI,
    SSTK_RD_LO,
    SSTK_RD_ONE,
    SSTK_DONE
  } sstk_state_t;

  sstk_state_t state;
  sstk_state_t next_state;
  logic [SSTK_DW-1:0] sp;
  logic [SSTK_DW-1:0] next_sp;
  logic [SSTK_DW-1:0] fp;
  logic is_exc;
  logic is_retfie;
  logic is_pop;
  logic is_load;
  logic [SSTK_DW-1:0] sp_inc;
  logic [SSTK_DW-1:0] sp_dec;
  logic [SSTK_DW-1:0] frame_hi;
  logic [SSTK_DW-1:0] next_addr;
  logic [SSTK_DW-1:0] next_wdata;
  logic next_we;
  logic next_re;
  logic [SSTK_DW-1:0] pop_data;
  logic [SSTK_PCW-1:0] ret_pc;
  logic [SSTK_SRL_W-1:0] ret_srl;
  logic ret_srl_valid;

  sstk_addr_step u_step (
    .ptr_i(sp),
    .inc_o(sp_inc),
    .dec_o(sp_dec)
  );

  sstk_frame_word u_frame (
    .pc_hi_i(pc_i[SSTK_PCW-1:SSTK_PC_LO_W]),
    .status_low_byte_i(status_low_byte_i),
    .is_exc_i(is_exc),
    .word_o(frame_hi)
  );

  wire start_pc_save = (op_i == SSTK_OP_CALL) || (op_i == SSTK_OP_EXC);
  wire start_pc_load = (op_i == SSTK_OP_RET) || (op_i == SSTK_OP_RETFIE);

  // Next state and the memory strobe for the coming cycle
  always_comb begin
    next_state = state;
    next_sp = sp;
    next_we = 1'b0;
    next_re = 1'b0;
    next_addr = sp;
    next_wdata = SSTK_FP_RESET;
    case (state)
      SSTK_IDLE: begin
        if (op_i == SSTK_OP_PUSH) begin
          next_we = 1'b1; // Write at the free word first [R4] [R3]
          next_wdata = push_data_i;
          next_state = SSTK_WR_HI;
        end else if (start_pc_save) begin
          next_we = 1'b1; // Low PC half first [R5] [R11]
          next_wdata = pc_i[SSTK_PC_LO_W-1:0];
          next_state = SSTK_WR_LO;
        end else if (op_i == SSTK_OP_POP) begin
          next_sp = sp_dec; // Decrement before the read [R4]
          next_re = 1'b1;
          next_addr = sp_dec;
          next_state = SSTK_RD_ONE;
        end else if (start_pc_load) begin
          next_sp = sp_dec; // [R11]
          next_re = 1'b1;
          next_addr = sp_dec;
          next_state = SSTK_RD_HI;
        end else if (wreg_we_i) begin
          next_sp = wreg_wdata_i & SSTK_ALIGN_MASK; // [R10] [R1]
        end
      end
      SSTK_WR_LO: begin
        next_sp = sp_inc; // Post-increment, then high half [R4] [R5]
        next_we = 1'b1;
        next_addr = sp_inc;
        next_wdata = frame_hi;
        next_state = SSTK_WR_HI;
      end
      SSTK_WR_HI: begin
        next_sp = sp_inc; // [R4] [R3]
        next_state = SSTK_DONE;
      end
      SSTK_RD_HI: begin
        next_sp = sp_dec;
        next_re = 1'b1;
        next_addr = sp_dec;
        next_state = SSTK_RD_LO;
      end
      SSTK_RD_LO: next_state = SSTK_DONE;
      SSTK_RD_ONE: next_state = SSTK_DONE;
      SSTK_DONE: next_state = SSTK_IDLE;
      default: next_state = SSTK_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= SSTK_IDLE;
      sp <= SSTK_RESET_ADDR; // [R2]
      mem_we_o <= 1'b0;
      mem_re_o <= 1'b0;
      mem_addr_o <= SSTK_RESET_ADDR;
      mem_wdata_o <= SSTK_FP_RESET;
    end else begin
      state <= next_state;
      sp <= next_sp & SSTK_ALIGN_MASK; // [R1]
      mem_we_o <= next_we;
      mem_re_o <= next_re;
      mem_addr_o <= next_addr; // [R8]
      mem_wdata_o <= next_wdata;
    end
  end

  // Op kind is latched at op start; pc_i stays held until done
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      is_exc <= 1'b0;
      is_retfie <= 1'b0;
      is_pop <= 1'b0;
      is_load <= 1'b0;
    end else if (state == SSTK_IDLE) begin
      is_exc <= (op_i == SSTK_OP_EXC); // [R7]
      is_retfie <= (op_i == SSTK_OP_RETFIE);
      is_pop <= (op_i == SSTK_OP_POP);
      is_load <= start_pc_load;
    end
  end

  // Read data returns one cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pop_data <= SSTK_FP_RESET;
      ret_pc <= '0;
      ret_srl <= SSTK_ZERO_BYTE;
      ret_srl_valid <= 1'b0;
    end else if (state == SSTK_RD_LO) begin
      ret_pc[SSTK_PCW-1:SSTK_PC_LO_W] <=
        mem_rdata_i[SSTK_DW-2:SSTK_SRL_W];
      ret_srl <= mem_rdata_i[SSTK_SRL_W-1:0];
      ret_srl_valid <= is_retfie;
    end else if (state == SSTK_DONE && is_pop) begin
      pop_data <= mem_rdata_i; // Data of the strobe one cycle back [R4]
    end else if (state == SSTK_DONE && is_load) begin
      ret_pc[SSTK_PC_LO_W-1:0] <= mem_rdata_i; // [R5]
    end
  end

  // Frame pointer kept here so its range limit is enforced [R9]
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fp <= SSTK_FP_RESET;
    end else if (fp_we_i) begin
      fp <= fp_wdata_i;
    end
  end

  assign stack_pointer_reg_o = sp;
  assign frame_pointer_reg_o = fp;
  assign fp_unpaged_o = frame_pointer_active_i; // [R9]
  assign extended_space_paging_o = 1'b0; // Never paged [R8]
  assign pop_data_o = pop_data;
  assign ret_pc_o = ret_pc;
  assign ret_srl_o = ret_srl;
  assign ret_srl_valid_o = ret_srl_valid;
  assign done_o = (state == SSTK_DONE);
endmodule

// *** sim/sstk_mem_model.sv ***
// Data memory seen by the stack core: one-cycle read, write on strobe.
// Assumes registered strobes and address from the core.
`timescale 1ns/1ps
module sstk_mem_model (
  input wire logic clk_sys_i,
  input wire logic mem_we_o,
  input wire logic mem_re_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [15:0] mem_wdata_o,
  output logic [15:0] mem_rdata_i
);
  logic [15:0] mem [logic [15:0]];
  initial mem_rdata_i = 16'hA5A5;
  // Outside a read the bus toggles, so stale data never passes as valid
  always @(posedge clk_sys_i) begin
    if (mem_we_o)
      mem[mem_addr_o] = mem_wdata_o;
    if (mem_re_o && mem.exists(mem_addr_o))
      mem_rdata_i <= mem[mem_addr_o];
    else
      mem_rdata_i <= ~mem_rdata_i;
  end
endmodule

// *** sim/sstk_chk.sv ***
// Checker for the stack core, watching its ports only.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
module sstk_chk (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire sstk_pkg::sstk_op_t op_i,
  input wire logic [22:0] pc_i,
  input wire logic [7:0] status_low_byte_i,
  input wire logic frame_pointer_active_i,
  input wire logic [15:0] stack_pointer_reg_o,
  input wire logic fp_unpaged_o,
  input wire logic mem_we_o,
  input wire logic mem_re_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [15:0] mem_wdata_o,
  input wire logic extended_space_paging_o,
  input wire logic done_o
);
  import sstk_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_sp_bit0_zero: assert property (!stack_pointer_reg_o[0])
    else $error("stack pointer bit 0 set");
  a_reset_load_sp: assert property ($past(rst_i) |->
    stack_pointer_reg_o == SSTK_RESET_ADDR)
    else $error("stack pointer not at reset address");
  a_no_paging: assert property (!extended_space_paging_o)
    else $error("paging used for stack");
  a_fp_unpaged: assert property (fp_unpaged_o == frame_pointer_active_i)
    else $error("frame pointer paging wrong");
  a_push_write_first: assert property (op_i == SSTK_OP_PUSH && mem_we_o
    |-> mem_addr_o == stack_pointer_reg_o)
    else $error("push not written at free word");
  a_pop_dec_first: assert property (op_i == SSTK_OP_POP && mem_re_o
    |-> mem_addr_o == stack_pointer_reg_o)
    else $error("pop read not after decrement");
  a_call_frame: assert property ($rose(mem_we_o) && op_i == SSTK_OP_CALL
    |-> mem_wdata_o == pc_i[15:0] ##1 mem_we_o && mem_wdata_o ==
    {1'b0, pc_i[22:16], SSTK_ZERO_BYTE} &&
    mem_addr_o == $past(mem_addr_o) + SSTK_WORD_STEP)
    else $error("call frame words wrong");
  a_exc_frame: assert property ($rose(mem_we_o) && op_i == SSTK_OP_EXC
    |-> mem_wdata_o == pc_i[15:0] ##1 mem_we_o && mem_wdata_o ==
    {1'b0, pc_i[22:16], status_low_byte_i})
    else $error("exception frame words wrong");
  a_done_bounded: assert property ($rose(op_i != SSTK_OP_NONE)
    |-> ##[2:5] done_o)
    else $error("operation did not complete");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
endmodule
bind sstk_core sstk_chk sstk_chk_i (.clk_sys_i, .rst_i, .op_i, .pc_i,
  .status_low_byte_i, .frame_pointer_active_i, .stack_pointer_reg_o,
  .fp_unpaged_o, .mem_we_o, .mem_re_o, .mem_addr_o, .mem_wdata_o,
  .extended_space_paging_o, .done_o);

// *** sim/sstk_core_bench.sv ***
// Self-checking bench for the stack core with a memory model.
// Assumes the hand-over timing: op held until done, dropped at done.
`timescale 1ns/1ps
module sstk_core_bench;
  import sstk_pkg::*;
  logic clk_sys_i = 0, rst_i = 1, wreg_we_i = 0, fap = 0;
  sstk_op_t op_i = SSTK_OP_NONE;
  logic [15:0] push_d = 0, wdat = 0, rdata, sp, fp, addr, wdata, pop_d;
  logic [15:0] e_sp, hi, lo;
  logic [22:0] pc = 0, ret_pc;
  logic [7:0] status_low_byte = 0, ret_srl;
  logic we, re, done, ret_v, fpu, edsp;
  logic [15:0] q[$];
  int bad_count = 0, n_compared = 0, seed = 32'hcfc3, cyc = 0;
  sstk_core sstk_core_i (.clk_sys_i, .rst_i, .op_i, .push_data_i(push_d),
    .pc_i(pc), .status_low_byte_i(status_low_byte), .wreg_we_i, .wreg_wdata_i(wdat),
    .fp_we_i(1'b0), .fp_wdata_i(16'h0000), .frame_pointer_active_i(fap),
    .mem_rdata_i(rdata), .stack_pointer_reg_o(sp), .frame_pointer_reg_o(fp),
    .fp_unpaged_o(fpu), .mem_we_o(we), .mem_re_o(re), .mem_addr_o(addr),
    .mem_wdata_o(wdata), .extended_space_paging_o(edsp), .pop_data_o(pop_d),
    .ret_pc_o(ret_pc), .ret_srl_o(ret_srl), .ret_srl_valid_o(ret_v),
    .done_o(done));
  sstk_mem_model sstk_mem_model_i (.clk_sys_i, .mem_we_o(we), .mem_re_o(re),
    .mem_addr_o(addr), .mem_wdata_o(wdata), .mem_rdata_i(rdata));
  always #5 clk_sys_i = ~clk_sys_i;
  // Whole run needs at most about 1200 cycles; the ceiling leaves ample margin
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [22:0] e, g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic run(input sstk_op_t o);
    int k;
    k = 0;
    op_i = o;
    do begin
      @(posedge clk_sys_i) #1;
      k++;
    end while (done !== 1'b1 && k < 10);
    chk("done", 1, k < 10);
    op_i = SSTK_OP_NONE;
    @(posedge clk_sys_i) #1;
  endtask
  task automatic wr_sp(input logic [15:0] v);
    wreg_we_i = 1;
    wdat = v;
    @(posedge clk_sys_i) #1;
    wreg_we_i = 0;
    e_sp = v & SSTK_ALIGN_MASK;
    q.delete();
  endtask
  task automatic stop_test();
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_i);
    #1 rst_i = 0;
    chk("sp_reset", SSTK_RESET_ADDR, sp);
    wr_sp(16'hFFF7);
    chk("sp_odd", e_sp, sp);
    for (int i = 0; i < 300; i++) begin
      pc = $random(seed);
      status_low_byte = $random(seed);
      push_d = $random(seed);
      fap = $random(seed);
      case ($unsigned($random(seed)) % 7)
        0: begin
          run(SSTK_OP_PUSH);
          q.push_back(push_d);
          e_sp += 2;
        end
        1: if (q.size() > 0) begin
          run(SSTK_OP_POP);
          e_sp -= 2;
          chk("pop_data", q.pop_back(), pop_d);
        end
        2, 3: begin
          run(i[0] ? SSTK_OP_EXC : SSTK_OP_CALL);
          q.push_back(pc[15:0]);
          q.push_back({1'b0, pc[22:16], i[0] ? status_low_byte : 8'h00});
          e_sp += 4;
        end
        4, 5: if (q.size() > 1) begin
          hi = q.pop_back();
          lo = q.pop_back();
          run(i[0] ? SSTK_OP_RETFIE : SSTK_OP_RET);
          e_sp -= 4;
          chk("ret_pc", {hi[14:8], lo}, ret_pc);
          if (i[0])
            chk("ret_srl", hi[7:0], ret_srl);
          chk("ret_srl_valid", i[0], ret_v);
        end
        default: wr_sp($random(seed));
      endcase
      chk("sp", e_sp, sp);
      chk("paging", 0, edsp);
      chk("fp_unpaged", fap, fpu);
    end
    rst_i = 1;
    @(posedge clk_sys_i) #1;
    rst_i = 0;
    chk("sp_rereset", SSTK_RESET_ADDR, sp);
    stop_test();
  end
endmodule
